// ---- hw/ibl_pkg.sv ----
/*
 Shared constants for the instrument bus latch bank and its controller:
 bus codes, select assignments, register offsets, fields and timing.
 Assumes a single 40 MHz core clock on both ends.
*/
package ibl_pkg;
   // ----------------------------------------------------------------
   // Bus codes
   // ----------------------------------------------------------------
   localparam logic [2:0] ENA_NIBBLE     = 3'h7;  // Whole-nibble group
   localparam logic [2:0] ENA_BITS       = 3'h6;  // Bit-addressable group
   localparam logic [2:0] SEL_IN_OVL_RD  = 3'h0;
   localparam logic [2:0] SEL_IN_GAIN_A  = 3'h1;
   localparam logic [2:0] SEL_IN_GAIN_B  = 3'h2;
   localparam logic [2:0] SEL_IN_GAIN_C  = 3'h3;
   localparam logic [2:0] SEL_OUT_OVL_RD = 3'h4;  // Also the parity code
   localparam logic [2:0] SEL_OUT_GAIN   = 3'h5;
   localparam logic [2:0] SEL_OUT_OVL_SET = 3'h6;
   localparam logic [2:0] SEL_IN_OVL_SET = 3'h7;
   localparam int         IN_SET_DBIT    = 1;     // Data bit that sets input flag
   localparam logic [3:0] GAIN_MIN       = 4'h0;
   localparam logic       OVL_RST_VAL    = 1'b0;  // Flags start tripped
   // ----------------------------------------------------------------
   // Controller registers (APB, one word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CMD    = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CTRL   = 8'h08;
   localparam int CMD_DATA_LSB = 0;
   localparam int CMD_SEL_LSB  = 4;
   localparam int CMD_ENA_LSB  = 8;
   localparam int ST_BUSY      = 0;
   localparam int ST_READBACK  = 1;
   localparam int ST_PARITY    = 2;
   localparam int ST_PAR_FAIL  = 3;
   localparam int ST_PAR_DONE  = 4;
   localparam int ST_POWER_UP  = 5;
   localparam int CT_REPEAT    = 0;
   localparam int CT_PAR_START = 1;
   localparam int CT_PWR_DONE  = 2;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_HZ         = 40_000_000;
   localparam int SPF_PERIOD_MS  = 30;
   localparam int SPF_PERIOD_CYC = SPF_PERIOD_MS * (CLK_HZ / 1000);
   localparam int STROBE_CYC     = 3;  // Enable low time per bus code

   typedef enum logic [1:0] {
      C_IDLE   = 2'b00,
      C_STROBE = 2'b01,
      C_WAIT   = 2'b10
   } ibl_ctl_state_e;
endpackage : ibl_pkg

// ---- hw/ibl_bus_if.sv ----
/*
 Instrument bus between controller and latch bank.
 Assumes both ends share core_clk; no tri-state, readback has own lines.
*/
`timescale 1ns/1ps
interface ibl_bus_if;
   logic [7:0] enableN;          // One line per enable code, active low
   logic [3:0] selectBits;
   logic [3:0] dataBits;         // True-high data
   logic       dataBit0TrueLow;  // Readback, inverted data bit 0
   logic       parityBit;        // Parity readback

   modport dev (input enableN, input selectBits, input dataBits,
                output dataBit0TrueLow, output parityBit);
   modport ctl (output enableN, output selectBits, output dataBits,
                input dataBit0TrueLow, input parityBit);
endinterface : ibl_bus_if

// ---- hw/ibl_latch_bank.sv ----
/*
 Latch bank end of the instrument bus: decoders, nibble latches,
 bit-addressable latches, overload flags, readback and parity.
 Assumes the bus comes from logic on core_clk; overload detector
 pins are asynchronous and are synchronised here.
*/
`timescale 1ns/1ps
module ibl_latch_bank
   import ibl_pkg::*;
#(
   parameter int NUM_BIT_LATCH = 2
)(
   input  wire logic                            core_clk,
   input  wire logic                            rst_n,
   input  wire logic                            clkEn,
   ibl_bus_if.dev                               bus,
   input  wire logic                            inOverload,
   input  wire logic                            outOverload,
   output logic [3:0]                           inGainA,
   output logic [3:0]                           inGainB,
   output logic [3:0]                           inGainC,
   output logic [3:0]                           outGain,
   output logic [NUM_BIT_LATCH-1:0][7:0]        bitLatch,
   output logic                                 inOvlOk,
   output logic                                 outOvlOk
);

   // ----------------------------------------------------------------
   // Elaboration check
   // ----------------------------------------------------------------
   // Each bit-addressable latch takes one data line, so four at most
   if (NUM_BIT_LATCH < 1 || NUM_BIT_LATCH > 4) begin : g_chk
      $error("NUM_BIT_LATCH must be 1 to 4");
   end

   // ----------------------------------------------------------------
   // Decoders
   // ----------------------------------------------------------------
   // One-of-eight decode, gated by its enable
   function automatic logic [7:0] dec8(input logic en, input logic [2:0] sel);
      dec8 = en ? (8'h01 << sel) : 8'h00;
   endfunction : dec8

   logic       grp7On;
   logic       grp6On;
   logic [7:0] nibSel;
   logic [7:0] bitSel;
   logic       setIn;
   logic       setOut;
   logic       dataParity;

   // Select bit 3 high keeps the nibble decoder dark
   assign grp7On     = ~bus.enableN[ENA_NIBBLE] & ~bus.selectBits[3];
   assign grp6On     = ~bus.enableN[ENA_BITS];
   assign nibSel     = dec8(grp7On, bus.selectBits[2:0]);
   assign bitSel     = dec8(grp6On, bus.selectBits[2:0]);
   assign setIn      = nibSel[SEL_IN_OVL_SET] & bus.dataBits[IN_SET_DBIT];
   assign setOut     = nibSel[SEL_OUT_OVL_SET];
   assign dataParity = ^bus.dataBits;

   // ----------------------------------------------------------------
   // Overload detector synchronisers
   // ----------------------------------------------------------------
   logic inMeta_q;
   logic inSync_q;
   logic outMeta_q;
   logic outSync_q;

   // Detector pins are asynchronous to core_clk
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         inMeta_q  <= 1'b0;
         inSync_q  <= 1'b0;
         outMeta_q <= 1'b0;
         outSync_q <= 1'b0;
      end else if (clkEn) begin
         inMeta_q  <= inOverload;
         inSync_q  <= inMeta_q;
         outMeta_q <= outOverload;
         outSync_q <= outMeta_q;
      end
   end

   // ----------------------------------------------------------------
   // Overload flags
   // ----------------------------------------------------------------
   logic inOvlOk_q;
   logic inOvlOk_d;
   logic outOvlOk_q;
   logic outOvlOk_d;

   // Detection beats a set in the same cycle: a live overload must win
   assign inOvlOk_d  = inSync_q ? 1'b0 : (setIn ? 1'b1 : inOvlOk_q);
   assign outOvlOk_d = outSync_q ? 1'b0 : (setOut ? 1'b1 : outOvlOk_q);

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         inOvlOk_q  <= OVL_RST_VAL;
         outOvlOk_q <= OVL_RST_VAL;
      end else if (clkEn) begin
         inOvlOk_q  <= inOvlOk_d;
         outOvlOk_q <= outOvlOk_d;
      end
   end

   assign inOvlOk  = inOvlOk_q;
   assign outOvlOk = outOvlOk_q;

   // ----------------------------------------------------------------
   // Whole-nibble gain latches
   // ----------------------------------------------------------------
   logic [3:0] inGainA_q;
   logic [3:0] inGainB_q;
   logic [3:0] inGainC_q;
   logic [3:0] outGain_q;

   // A cleared flag holds its gains at minimum and blocks loads,
   // so gain cannot creep back while the overload stands
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         inGainA_q <= GAIN_MIN;
         inGainB_q <= GAIN_MIN;
         inGainC_q <= GAIN_MIN;
         outGain_q <= GAIN_MIN;
      end else if (clkEn) begin
         if (!inOvlOk_q) begin
            inGainA_q <= GAIN_MIN;
            inGainB_q <= GAIN_MIN;
            inGainC_q <= GAIN_MIN;
         end else begin
            if (nibSel[SEL_IN_GAIN_A]) inGainA_q <= bus.dataBits;
            if (nibSel[SEL_IN_GAIN_B]) inGainB_q <= bus.dataBits;
            if (nibSel[SEL_IN_GAIN_C]) inGainC_q <= bus.dataBits;
         end
         if (!outOvlOk_q) begin
            outGain_q <= GAIN_MIN;
         end else if (nibSel[SEL_OUT_GAIN]) begin
            outGain_q <= bus.dataBits;
         end
      end
   end

   assign inGainA = inGainA_q;
   assign inGainB = inGainB_q;
   assign inGainC = inGainC_q;
   assign outGain = outGain_q;

   // ----------------------------------------------------------------
   // Bit-addressable latches
   // ----------------------------------------------------------------
   logic [NUM_BIT_LATCH-1:0][7:0] bitLatch_q;

   // Latch n takes data bit n, so one code can load several latches
   for (genvar g = 0; g < NUM_BIT_LATCH; g++) begin : g_bit
      for (genvar i = 0; i < 8; i++) begin : g_out
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               bitLatch_q[g][i] <= 1'b0;
            end else if (clkEn && bitSel[i]) begin
               bitLatch_q[g][i] <= bus.dataBits[g];
            end
         end
      end
   end

   assign bitLatch = bitLatch_q;

   // ----------------------------------------------------------------
   // Readback and parity
   // ----------------------------------------------------------------
   logic rbLow_q;
   logic parity_q;
   logic rbLow_d;

   // Idle readback line rests high; flags answer on their select codes
   assign rbLow_d = nibSel[SEL_IN_OVL_RD]  ? inOvlOk_q :
                    nibSel[SEL_OUT_OVL_RD] ? outOvlOk_q : 1'b1;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rbLow_q  <= 1'b1;
         parity_q <= 1'b0;
      end else if (clkEn) begin
         rbLow_q  <= rbLow_d;
         parity_q <= nibSel[SEL_OUT_OVL_RD] & dataParity;
      end
   end

   assign bus.dataBit0TrueLow = rbLow_q;
   assign bus.parityBit       = parity_q;

endmodule : ibl_latch_bank

// ---- hw/ibl_bus_ctl.sv ----
/*
 Controller end of the instrument bus: APB registers, bus strobe
 sequencer, repeated special-function output and power-up parity test.
 Assumes the latch bank runs on the same core_clk.
*/
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/1ps
module ibl_bus_ctl
   import ibl_pkg::*;
#(
   parameter int unsigned PERIOD_CYC = SPF_PERIOD_CYC
)(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic        clkEn,
   ibl_bus_if.ctl           bus,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr
);

   if (PERIOD_CYC <= STROBE_CYC + 1 || PERIOD_CYC >= (1 << 24)) begin : g_chk
      $error("PERIOD_CYC out of range");
   end

   // ----------------------------------------------------------------
   // APB slave: zero wait state, answer prepared in the setup cycle
   // ----------------------------------------------------------------
   logic        pready_q;
   logic        pslverr_q;
   logic [31:0] prdata_q;
   logic        setup;
   logic        wrDone;
   logic        mapped;
   logic        repeat_q;
   logic        powerUp_q;
   logic        parDone_q;
   logic        parFail_q;
   logic        rbLow_q;
   logic        parity_q;
   logic        busy;
   logic [31:0] rdMux;

   assign setup  = psel & ~penable;
   assign wrDone = psel & penable & pready_q & pwrite & ~pslverr_q;
   assign mapped = (paddr == REG_CMD) | (paddr == REG_STATUS) | (paddr == REG_CTRL);
   assign rdMux  = (paddr == REG_STATUS) ?
                   32'({powerUp_q, parDone_q, parFail_q, parity_q, rbLow_q, busy}) :
                   (paddr == REG_CTRL) ? 32'(repeat_q) : 32'h0000_0000;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else if (clkEn) begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         if (setup) prdata_q <= rdMux;
      end
   end

   assign pready  = pready_q;
   assign pslverr = pslverr_q;
   assign prdata  = prdata_q;

   // ----------------------------------------------------------------
   // Bus sequencer
   // ----------------------------------------------------------------
   ibl_ctl_state_e state_q;
   logic [10:0]    cmd_q;
   logic           cmdPend_q;
   logic           parRun_q;
   logic [3:0]     parIdx_q;
   logic [23:0]    cnt_q;
   logic [7:0]     enableN_q;
   logic [3:0]     select_q;
   logic [3:0]     data_q;
   logic           wrCmd;
   logic           wrCtrl;
   logic [10:0]    code;
   logic           lastStrobe;
   logic           parWant;

   assign wrCmd   = wrDone & (paddr == REG_CMD);
   assign wrCtrl  = wrDone & (paddr == REG_CTRL);
   assign busy    = (state_q != C_IDLE) | cmdPend_q | parRun_q;
   // Parity test walks codes 740..74F in order
   assign code    = parRun_q ? {ENA_NIBBLE, 1'b0, SEL_OUT_OVL_RD, parIdx_q} : cmd_q;
   assign lastStrobe = (cnt_q == 24'(STROBE_CYC - 1));
   assign parWant = ^parIdx_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q   <= C_IDLE;
         cmd_q     <= 11'h000;
         cmdPend_q <= 1'b0;
         repeat_q  <= 1'b0;
         powerUp_q <= 1'b1;
         parRun_q  <= 1'b0;
         parIdx_q  <= 4'h0;
         parDone_q <= 1'b0;
         parFail_q <= 1'b0;
         rbLow_q   <= 1'b1;
         parity_q  <= 1'b0;
         cnt_q     <= 24'h000000;
         enableN_q <= 8'hff;
         select_q  <= 4'h0;
         data_q    <= 4'h0;
      end else if (clkEn) begin
         // A new command is refused while one is pending or running
         if (wrCmd && !busy) begin
            cmd_q     <= pwdata[CMD_ENA_LSB+2:CMD_DATA_LSB];
            cmdPend_q <= 1'b1;
         end
         if (wrCtrl) begin
            repeat_q <= pwdata[CT_REPEAT];
            if (pwdata[CT_PWR_DONE]) powerUp_q <= 1'b0;
            // The data-line test exists only for the power-up window
            if (pwdata[CT_PAR_START] && powerUp_q && !busy) begin
               parRun_q  <= 1'b1;
               parIdx_q  <= 4'h0;
               parDone_q <= 1'b0;
               parFail_q <= 1'b0;
            end
         end
         unique case (state_q)
            C_IDLE: begin
               if (parRun_q || cmdPend_q) begin
                  enableN_q <= ~(8'h01 << code[10:8]);
                  select_q  <= code[7:4];
                  data_q    <= code[3:0];
                  cnt_q     <= 24'h000000;
                  state_q   <= C_STROBE;
               end
            end
            C_STROBE: begin
               cnt_q <= cnt_q + 24'h000001;
               if (lastStrobe) begin
                  enableN_q <= 8'hff;
                  rbLow_q   <= bus.dataBit0TrueLow;
                  parity_q  <= bus.parityBit;
                  if (parRun_q) begin
                     if (bus.parityBit != parWant) parFail_q <= 1'b1;
                     parIdx_q <= parIdx_q + 4'h1;
                     if (parIdx_q == 4'hf) begin
                        parRun_q  <= 1'b0;
                        parDone_q <= 1'b1;
                     end
                     state_q <= C_IDLE;
                  end else if (repeat_q) begin
                     state_q <= C_WAIT;
                  end else begin
                     cmdPend_q <= 1'b0;
                     state_q   <= C_IDLE;
                  end
               end
            end
            C_WAIT: begin
               // All enables stay high between repeated pulses
               cnt_q <= cnt_q + 24'h000001;
               if (!repeat_q) begin
                  cmdPend_q <= 1'b0;
                  state_q   <= C_IDLE;
               end else if (cnt_q == 24'(PERIOD_CYC - 2)) begin
                  state_q <= C_IDLE;
               end
            end
            default: state_q <= C_IDLE;
         endcase
      end
   end

   assign bus.enableN    = enableN_q;
   assign bus.selectBits = select_q;
   assign bus.dataBits   = data_q;

endmodule : ibl_bus_ctl

// ---- dv/ibl_monitor.sv ----
/*
 Checker for the instrument bus between controller and latch bank.
 Assumes the bench instantiates it beside the bus interface, one clock.
*/
`timescale 1ns/1ps
module ibl_monitor
   import ibl_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic [7:0] enableN,
   input wire logic [3:0] selectBits,
   input wire logic [3:0] dataBits,
   input wire logic       dataBit0TrueLow,
   input wire logic       parityBit
);
   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   // Named decodes keep the properties short
   wire logic busIdle  = &enableN;
   wire logic parCode  = !enableN[ENA_NIBBLE] && selectBits == {1'b0, SEL_OUT_OVL_RD};
   wire logic inRdCode = !enableN[ENA_NIBBLE] && selectBits == {1'b0, SEL_IN_OVL_RD};
   wire logic pairCode = !enableN[ENA_BITS] && selectBits == 4'h3 && dataBits == 4'h3;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   a_enable_one_hot: assert property (busIdle || $onehot(~enableN))
      else $error("more than one enable line low");
   a_strobe_three: assert property ($fell(busIdle) |-> (!busIdle)[*3] ##1 busIdle)
      else $error("enable strobe not three cycles long");
   a_strobe_spacing: assert property ($fell(busIdle) |=> (!$fell(busIdle))[*3])
      else $error("bus codes too close together");
   a_enable_hold: assert property (!busIdle && !$fell(busIdle) |-> $stable(enableN))
      else $error("enable lines moved inside a strobe");
   a_code_hold: assert property (!$fell(busIdle) |-> $stable({selectBits, dataBits}))
      else $error("select or data moved outside a strobe start");
   a_parity_xor: assert property (parCode && $past(parCode) |-> parityBit == ^dataBits)
      else $error("parity readback is not the xor of the data");
   a_parity_after: assert property ($rose(busIdle) && $past(parCode) |-> parityBit == ^dataBits)
      else $error("parity readback lost after the strobe");
   // The first read cycle still shows the idle level, so steadiness starts one cycle later
   a_readback_hold: assert property (inRdCode && $past(inRdCode) && $past(inRdCode, 2)
      |-> $stable(dataBit0TrueLow))
      else $error("overload readback unsteady during read");

   // Main traffic seen at least once
   c_parity_code: cover property (parCode && $past(parCode));
   c_in_read:     cover property (inRdCode);
   c_pair_load:   cover property (pairCode);
endmodule : ibl_monitor

// ---- dv/instrument_bus_latch_decoder_test.sv ----
/*
 Self-checking bench: controller and latch bank joined by the bus,
 driven over APB. Assumes a shortened repeat period of PER cycles.
*/
`timescale 1ns/1ps
module instrument_bus_latch_decoder_test;
   import ibl_pkg::*;
   localparam int PER = 20;
   logic            core_clk, rst_n, inOverload, outOverload;
   logic            psel, penable, pwrite, pready, pslverr, err;
   logic [7:0]      paddr;
   logic [31:0]     pwdata, prdata, rd;
   logic [3:0]      inGainA, inGainB, inGainC, outGain;
   logic [1:0][7:0] bitLatch;
   logic            inOvlOk, outOvlOk, clkEn;
   int              n_mismatch = 0;
   int              n_checks = 0;

   // ----------------------------------------------------------------
   // Both ends and the checker
   // ----------------------------------------------------------------
   ibl_bus_if ibl_bus_if_inst ();
   ibl_bus_ctl #(.PERIOD_CYC(PER)) ibl_bus_ctl_inst (.core_clk(core_clk), .rst_n(rst_n),
      .clkEn(clkEn), .bus(ibl_bus_if_inst), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   ibl_latch_bank ibl_latch_bank_inst (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
      .bus(ibl_bus_if_inst), .inOverload(inOverload), .outOverload(outOverload),
      .inGainA(inGainA), .inGainB(inGainB), .inGainC(inGainC), .outGain(outGain),
      .bitLatch(bitLatch), .inOvlOk(inOvlOk), .outOvlOk(outOvlOk));
   ibl_monitor ibl_monitor_inst (.core_clk(core_clk), .rst_n(rst_n),
      .enableN(ibl_bus_if_inst.enableN), .selectBits(ibl_bus_if_inst.selectBits),
      .dataBits(ibl_bus_if_inst.dataBits), .dataBit0TrueLow(ibl_bus_if_inst.dataBit0TrueLow),
      .parityBit(ibl_bus_if_inst.parityBit));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic summarize();
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : summarize
   task automatic hang();
      n_mismatch++;
      summarize();
   endtask : hang
   // One APB transfer; an edge always passes before setup so psel is never set twice
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do begin
         @(posedge core_clk);
         n++;
         if (n > 50) hang();
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb
   task automatic waitStatus(input int b, input logic v);
      int n;
      n = 0;
      do begin
         apb(1'b0, REG_STATUS, 32'h0);
         n++;
         if (n > 100) hang();
      end while (rd[b] !== v);
   endtask : waitStatus
   // Send one bus code and wait until the controller has finished it
   task automatic cmd(input logic [11:0] c);
      apb(1'b1, REG_CMD, {20'h0, c});
      waitStatus(ST_BUSY, 1'b0);
   endtask : cmd
   task automatic waitGain(input bit outSide);
      int n;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (n > 20) hang();
      end while ((outSide ? outGain : (inGainA | inGainB | inGainC)) !== 4'h0);
   endtask : waitGain
   task automatic waitEn5(input logic v, inout int n);
      int k;
      k = 0;
      do begin
         @(posedge core_clk);
         n++;
         k++;
         if (k > PER * 4) hang();
      end while (ibl_bus_if_inst.enableN[5] !== v);
   endtask : waitEn5

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      check("enableN", ibl_bus_if_inst.enableN, 8'hff);
      check("gains", {inGainA, inGainB, inGainC, outGain}, 16'h0);
      check("bitLatch", bitLatch, 16'h0);
      apb(1'b0, 8'h0c, 32'h0);
      check("unmapped err", err, 1'b1);
      check("unmapped data", rd, 32'h0);
      apb(1'b0, REG_STATUS, 32'h0);
      check("powerUp", rd[ST_POWER_UP], 1'b1);
      cmd(12'h700);
      check("in flag read", rd[ST_READBACK], 1'b0);
   endtask : t_reset
   task automatic t_parity();
      apb(1'b1, REG_CTRL, 32'h1 << CT_PAR_START);
      waitStatus(ST_PAR_DONE, 1'b1);
      check("parity fail", rd[ST_PAR_FAIL], 1'b0);
      apb(1'b1, REG_CTRL, 32'h1 << CT_PWR_DONE);
      apb(1'b1, REG_CTRL, 32'h1 << CT_PAR_START);
      apb(1'b0, REG_STATUS, 32'h0);
      check("late parity", rd[ST_BUSY +: 1] | rd[ST_POWER_UP +: 1], 1'b0);
   endtask : t_parity
   task automatic t_flags();
      cmd(12'h771);
      check("in flag no set", inOvlOk, 1'b0);
      cmd(12'h772);
      cmd(12'h700);
      check("in flag read", rd[ST_READBACK], 1'b1);
      check("in flag", inOvlOk, 1'b1);
      // A frozen bank must ignore even a live overload
      clkEn <= 1'b0;
      inOverload <= 1'b1;
      repeat (6) @(posedge core_clk);
      check("frozen flag", inOvlOk, 1'b1);
      inOverload <= 1'b0;
      clkEn <= 1'b1;
      cmd(12'h740);
      check("out flag read", rd[ST_READBACK], 1'b0);
      cmd(12'h760);
      cmd(12'h740);
      check("out flag set", {rd[ST_READBACK], outOvlOk}, 2'b11);
   endtask : t_flags
   task automatic t_nibble();
      cmd(12'h715);
      cmd(12'h72c);
      cmd(12'h73a);
      cmd(12'h759);
      check("gains", {inGainA, inGainB, inGainC, outGain}, 16'h5ca9);
      cmd(12'h7b3);
      check("s3 high", inGainC, 4'ha);
   endtask : t_nibble
   task automatic t_bits();
      cmd(12'h623);
      cmd(12'h631);
      check("bits a", bitLatch, {8'h04, 8'h0c});
      cmd(12'h633);
      check("bits b", bitLatch, {8'h0c, 8'h0c});
      cmd(12'h622);
      check("bits c", bitLatch, {8'h0c, 8'h08});
      cmd(12'h6a3);
      check("bits d", bitLatch, {8'h0c, 8'h0c});
   endtask : t_bits
   task automatic t_overload();
      inOverload <= 1'b1;
      waitGain(1'b0);
      inOverload <= 1'b0;
      check("in flag", inOvlOk, 1'b0);
      check("out gain kept", outGain, 4'h9);
      check("bits kept", bitLatch, {8'h0c, 8'h0c});
      cmd(12'h712);
      check("in gain forced", inGainA, GAIN_MIN);
      cmd(12'h700);
      check("in flag read", rd[ST_READBACK], 1'b0);
      outOverload <= 1'b1;
      waitGain(1'b1);
      outOverload <= 1'b0;
      check("out flag", outOvlOk, 1'b0);
      cmd(12'h740);
      check("out flag read", rd[ST_READBACK], 1'b0);
   endtask : t_overload
   task automatic t_repeat();
      int n;
      n = 0;
      apb(1'b1, REG_CTRL, 32'h1 << CT_REPEAT);
      apb(1'b1, REG_CMD, 32'h500);
      waitEn5(1'b0, n);
      check("one enable", ibl_bus_if_inst.enableN, 8'hdf);
      n = 0;
      waitEn5(1'b1, n);
      waitEn5(1'b0, n);
      check("repeat period", n, PER);
      // A command written while the repeat runs must be refused
      apb(1'b1, REG_CMD, 32'h671);
      apb(1'b1, REG_CTRL, 32'h0);
      waitStatus(ST_BUSY, 1'b0);
      check("enables idle", ibl_bus_if_inst.enableN, 8'hff);
      check("busy cmd refused", bitLatch, {8'h0c, 8'h0c});
   endtask : t_repeat

   // ----------------------------------------------------------------
   // Clock, reset and sequence
   // ----------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // Inputs get values at time zero; reset held for ten cycles
   initial begin
      rst_n = 1'b0; inOverload = 1'b0; outOverload = 1'b0; clkEn = 1'b1;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h0; pwdata = 32'h0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_parity();
      t_flags();
      t_nibble();
      t_bits();
      t_overload();
      t_repeat();
      summarize();
   end
endmodule : instrument_bus_latch_decoder_test
